// file: sms_link.sv
`timescale 1ns/1ns
`default_nettype none
module sms_link (
  // Clock and reset
  input wire logic lclk_i,
  input wire logic rst_i,
  // Sample handshake from the host domain
  input wire logic req_tgl_i,
  input wire logic [15:0] tx_i,
  input wire logic [4:0] width_i,
  input wire logic pol_i,
  input wire logic pha_i,
  input wire logic [15:0] half_i,
  output logic ack_tgl_o,
  output logic [15:0] rx_o,
  // Serial pins
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o
);

  typedef struct packed {
    sms_pkg::sms_lst_t st;
    logic req_seen;
    logic ack;
    logic [15:0] sh;
    logic [15:0] rx;
    logic [5:0] edges;
    logic [15:0] hc;
    logic [15:0] half;
    logic [4:0] wid;
    logic pha;
    logic cpol;
    logic sck;
    logic mosi;
  } sms_link_t;

  sms_link_t r;
  sms_link_t next_r;
  logic rst_m, rst_l, req_m, req_s, miso_m, miso_s, pol_m, pol_s;
  logic [15:0] aligned;
  logic sample_now;

  // ---------------------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge lclk_i) begin
    rst_m <= rst_i;
    rst_l <= rst_m;
    req_m <= req_tgl_i;
    req_s <= req_m;
    miso_m <= miso_i;
    miso_s <= miso_m;
    pol_m <= pol_i;
    pol_s <= pol_m;
  end

  // Bundle is stable here: host holds it until the acknowledge returns
  assign aligned = 16'(tx_i << (5'h10 - width_i));
  assign sample_now = r.edges[0] ^ ~r.pha;

  // ---------------------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    case (r.st)
      sms_pkg::L_IDLE: begin
        next_r.sck = pol_s;
        if (req_s != r.req_seen) begin
          next_r.req_seen = req_s;
          next_r.wid = width_i;
          next_r.pha = pha_i;
          next_r.cpol = pol_i;
          next_r.half = half_i;
          next_r.hc = half_i;
          next_r.edges = 6'h00;
          next_r.rx = 16'h0000;
          next_r.sh = aligned;
          if (!pha_i) begin
            next_r.mosi = aligned[15];
            next_r.sh = 16'(aligned << 1);
          end
          next_r.st = sms_pkg::L_RUN;
        end
      end
      sms_pkg::L_RUN: begin
        if (r.hc > 16'h0001) begin
          next_r.hc = r.hc - 16'h0001;
        end else begin
          next_r.hc = r.half;
          next_r.sck = ~r.sck;
          if (sample_now) begin
            next_r.rx = {r.rx[14:0], miso_s};
          end else begin
            next_r.mosi = r.sh[15];
            next_r.sh = 16'(r.sh << 1);
          end
          next_r.edges = r.edges + 6'h01;
          if (r.edges == 6'({r.wid, 1'b0} - 6'h01)) begin
            next_r.ack = ~r.ack;
            next_r.st = sms_pkg::L_IDLE;
          end
        end
      end
      default: next_r.st = sms_pkg::L_IDLE;
    endcase
  end

  always_ff @(posedge lclk_i) begin
    if (rst_l) begin
      r <= '0;
      r.st <= sms_pkg::L_IDLE;
      r.req_seen <= req_s;
      r.wid <= sms_pkg::WIDTH_RST;
      r.half <= 16'h0001;
      r.hc <= 16'h0001;
    end else begin
      r <= next_r;
    end
  end

  assign ack_tgl_o = r.ack;
  assign rx_o = r.rx;
  assign sck_o = r.sck;
  assign mosi_o = r.mosi;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  idle_level_a: assert property (@(posedge lclk_i) disable iff (rst_l)
    (r.st == sms_pkg::L_IDLE) ##1 (r.st == sms_pkg::L_IDLE)
      |-> r.sck == $past(pol_s))
    else $error("serial clock not at idle level");
  first_bit_a: assert property (@(posedge lclk_i) disable iff (rst_l)
    $rose(r.st == sms_pkg::L_RUN) && !r.pha |-> r.mosi == $past(aligned[15]))
    else $error("first bit not driven before first edge");
  ack_edges_a: assert property (@(posedge lclk_i) disable iff (rst_l)
    $changed(r.ack) |-> $past(r.edges) == 6'({r.wid, 1'b0} - 6'h01))
    else $error("sample ended after wrong edge count");
  msb_load_a: assert property (@(posedge lclk_i) disable iff (rst_l)
    $rose(r.st == sms_pkg::L_RUN) && r.pha |-> r.sh == $past(aligned))
    else $error("sample not aligned msb first");

endmodule : sms_link
`default_nettype wire

// file: sms_pkg.sv
`default_nettype none
// -----------------------------------------------------------------------------
// Functional notes
// - Exchange returns as many received bytes as it transmitted, barring errors; a dropped tail byte returns none.
// - Samples are big-endian in fewest bytes; unused upper received bits are zero.
// - Padding bits above the sample width are ignored; only width bits shift.
// - A trailing partial sample is dropped unshifted and raises a warning.
// - Polarity 0 idles the serial clock low, 1 idles it high.
// - Phase 0 centres each bit on the first edge, phase 1 on the second.
// - Polarity defaults to idle low and phase to first edge.
// - Unsupported rate falls back to the next lower supported rate, with warning.
// - A rate below every supported rate is refused with an error.
// - Mode and rate commands act on the port when they are executed.
// - Select-high command drives the named select line high at that point.
// - Select-low command drives the named select line low at that point.
// - Sample width defaults to eight bits.
// - Serial clock defaults to 1000 kHz.
// - Select line index defaults to zero.
// -----------------------------------------------------------------------------
package sms_pkg;

  localparam int unsigned MAX_W = 32'h0000_0010;
  localparam logic [4:0] WIDTH_MAX = 5'h10;
  localparam logic [4:0] WIDTH_RST = 5'h08;
  localparam logic [2:0] RATE_RST_IDX = 3'h3;
  localparam logic POL_RST = 1'b0;
  localparam logic PHA_RST = 1'b0;
  localparam int unsigned SEL_W = 32'h0000_0002;
  localparam logic [1:0] SEL_IDX_RST = 2'h0;
  // Link clock rate in kHz, used to derive serial half periods
  localparam int unsigned LINK_KHZ = 32'h0002_8B0A;
  localparam int unsigned RATE_COUNT = 32'h0000_0008;

  typedef enum logic [2:0] {
    CMD_EXCHANGE = 3'h0,
    CMD_MODE = 3'h1,
    CMD_RATE = 3'h2,
    CMD_SEL_LOW = 3'h3,
    CMD_SEL_HIGH = 3'h4,
    CMD_SELECT = 3'h5,
    CMD_WIDTH = 3'h6
  } sms_cmd_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_GATHER = 5'h02,
    H_WAIT = 5'h04,
    H_EMIT = 5'h08,
    H_DROP = 5'h10
  } sms_hst_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'h1,
    L_RUN = 2'h2
  } sms_lst_t;

  typedef struct packed {
    logic ok;
    logic exact;
    logic [2:0] idx;
  } sms_rate_t;

  // Supported serial rates in kHz, fastest first
  function automatic logic [15:0] rate_khz(input logic [2:0] idx);
    case (idx)
      3'h0: return 16'h1F40;
      3'h1: return 16'h0FA0;
      3'h2: return 16'h07D0;
      3'h3: return 16'h03E8;
      3'h4: return 16'h01F4;
      3'h5: return 16'h00FA;
      3'h6: return 16'h0064;
      default: return 16'h0032;
    endcase
  endfunction : rate_khz

  function automatic logic [15:0] half_cycles(input logic [2:0] idx);
    return 16'(LINK_KHZ / (32'h0000_0002 * 32'(rate_khz(idx))));
  endfunction : half_cycles

  function automatic sms_rate_t rate_pick(input logic [15:0] req);
    sms_rate_t res;
    res = '0;
    for (int i = 0; i < RATE_COUNT; i++) begin
      if (!res.ok && rate_khz(3'(i)) <= req) begin
        res.ok = 1'b1;
        res.idx = 3'(i);
        res.exact = (rate_khz(3'(i)) == req);
      end
    end
    return res;
  endfunction : rate_pick

  function automatic logic [1:0] bytes_per(input logic [4:0] width);
    return (width > 5'h08) ? 2'h2 : 2'h1;
  endfunction : bytes_per

  function automatic logic [15:0] width_mask(input logic [4:0] width);
    return 16'((32'h0000_0001 << width) - 32'h0000_0001);
  endfunction : width_mask

endpackage : sms_pkg
`default_nettype wire

// file: sms_slave.sv
`timescale 1ns/1ns
`default_nettype none
module sms_slave (
  // Serial pins
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic [3:0] sel_i,
  output logic miso_o,
  // Bench side
  input wire logic pol_i,
  input wire logic pha_i,
  input wire logic [15:0] resp_i,
  output logic [15:0] got_o,
  output int edges_o,
  output int half_o
);
  logic q = 1'b0;
  logic lead;
  logic act_d = 1'b0;
  logic [3:0] k;
  realtime last = 0.0;
  wire logic act = ~&sel_i;
  assign miso_o = q;
  // One process owns every output; select edges are told apart from clocks
  always @(act or sclk_i) begin
    if (act !== act_d) begin
      act_d = act;
      if (act === 1'b1) begin
        k = 4'h0;
        q = resp_i[15];
        edges_o = 0;
        got_o = 16'h0000;
      end else begin
        // Released line shows the inverse so a stale bit cannot pass as data
        q = ~q;
      end
    end else if (act === 1'b1) begin
      edges_o++;
      half_o = int'($realtime - last);
      last = $realtime;
      lead = (sclk_i != pol_i);
      if (lead == pha_i) begin
        q = resp_i[4'hf - k];
      end else begin
        got_o = {got_o[14:0], mosi_i};
        k++;
      end
    end
  end
endmodule : sms_slave
`default_nettype wire

// file: sms_top.sv
`timescale 1ns/1ns
`default_nettype none
module sms_top #(
  parameter int unsigned NUM_SEL = 32'h0000_0004
) (
  // Clocks and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic LINK_CLK_I,
  // Command port
  input wire logic CMD_VALID_I,
  input wire logic [2:0] CMD_CODE_I,
  input wire logic [15:0] CMD_ARG_I,
  output logic CMD_READY_O,
  // Transmit byte stream
  input wire logic TX_VALID_I,
  input wire logic [7:0] TX_BYTE_I,
  output logic TX_READY_O,
  // Receive byte stream
  output logic RX_VALID_O,
  output logic [7:0] RX_BYTE_O,
  // Status
  output logic DONE_O,
  output logic WARN_O,
  output logic ERR_O,
  output logic [15:0] RECEIVE_BYTE_COUNT_O,
  // Serial pins
  output logic SERIAL_CLK_O,
  output logic MOSI_O,
  input wire logic MISO_I,
  output logic [NUM_SEL-1:0] SELECT_O
);

  typedef struct packed {
    sms_pkg::sms_hst_t st;
    logic pol;
    logic pha;
    logic [2:0] rate_idx;
    logic [4:0] width;
    logic [sms_pkg::SEL_W-1:0] sel_idx;
    logic [NUM_SEL-1:0] sel;
    logic prev;
    logic [15:0] total;
    logic [15:0] remain;
    logic tail;
    logic [15:0] rcount;
    logic [1:0] bcnt;
    logic [15:0] txs;
    logic [15:0] rxs;
    logic req;
    logic ack_seen;
    logic tx_rdy;
    logic rx_vld;
    logic [7:0] rx_byte;
    logic done;
    logic warn;
    logic err;
    logic cmd_rdy;
  } sms_host_t;

  sms_host_t r;
  sms_host_t next_r;
  logic ack_m, ack_s;
  logic ack_tgl;
  logic [15:0] link_rx;
  logic cmd_acc, tx_acc;
  logic [1:0] bps;
  logic [15:0] mask;
  sms_pkg::sms_rate_t pick;
  logic [15:0] whole;

  function automatic sms_host_t host_reset();
    sms_host_t v;
    v = '0;
    v.st = sms_pkg::H_IDLE;
    v.pol = sms_pkg::POL_RST;
    v.pha = sms_pkg::PHA_RST;
    v.rate_idx = sms_pkg::RATE_RST_IDX;
    v.width = sms_pkg::WIDTH_RST;
    v.sel_idx = sms_pkg::SEL_IDX_RST;
    v.sel = '1;
    v.cmd_rdy = 1'b1;
    return v;
  endfunction : host_reset

  // ---------------------------------------------------------------------------
  // Link side engine
  // ---------------------------------------------------------------------------
  sms_link u_link (
    .lclk_i(LINK_CLK_I),
    .rst_i(RST_I),
    .req_tgl_i(r.req),
    .tx_i(r.txs),
    .width_i(r.width),
    .pol_i(r.pol),
    .pha_i(r.pha),
    .half_i(sms_pkg::half_cycles(r.rate_idx)),
    .ack_tgl_o(ack_tgl),
    .rx_o(link_rx),
    .miso_i(MISO_I),
    .sck_o(SERIAL_CLK_O),
    .mosi_o(MOSI_O)
  );

  always_ff @(posedge CLK_I) begin
    ack_m <= ack_tgl;
    ack_s <= ack_m;
  end

  assign cmd_acc = CMD_VALID_I && r.cmd_rdy;
  assign tx_acc = TX_VALID_I && r.tx_rdy;
  assign bps = sms_pkg::bytes_per(r.width);
  assign mask = sms_pkg::width_mask(r.width);
  assign pick = sms_pkg::rate_pick(CMD_ARG_I);
  // Bytes that form whole samples; an odd byte at 2 bytes/sample is a tail
  assign whole = (bps == 2'h2) ? {CMD_ARG_I[15:1], 1'b0} : CMD_ARG_I;

  // ---------------------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.rx_vld = 1'b0;
    case (r.st)
      sms_pkg::H_IDLE: begin
        if (cmd_acc) begin
          // Status reflects only the latest command
          next_r.warn = 1'b0;
          next_r.err = 1'b0;
          next_r.done = 1'b1;
          case (CMD_CODE_I)
            sms_pkg::CMD_EXCHANGE: begin
              if (CMD_ARG_I == 16'h0000) begin
                next_r.err = 1'b1;
              end else begin
                next_r.done = 1'b0;
                next_r.cmd_rdy = 1'b0;
                next_r.tx_rdy = 1'b1;
                next_r.total = CMD_ARG_I;
                next_r.remain = whole;
                next_r.tail = (bps == 2'h2) && CMD_ARG_I[0];
                next_r.rcount = 16'h0000;
                next_r.bcnt = 2'h0;
                next_r.prev = r.sel[r.sel_idx];
                if (whole == 16'h0000) begin
                  next_r.st = sms_pkg::H_DROP;
                end else begin
                  next_r.sel[r.sel_idx] = 1'b0;
                  next_r.st = sms_pkg::H_GATHER;
                end
              end
            end
            sms_pkg::CMD_MODE: begin
              next_r.pol = CMD_ARG_I[0];
              next_r.pha = CMD_ARG_I[1];
            end
            sms_pkg::CMD_RATE: begin
              if (!pick.ok) begin
                next_r.err = 1'b1;
              end else begin
                next_r.rate_idx = pick.idx;
                next_r.warn = !pick.exact;
              end
            end
            sms_pkg::CMD_SEL_LOW: begin
              next_r.sel[CMD_ARG_I[sms_pkg::SEL_W-1:0]] = 1'b0;
            end
            sms_pkg::CMD_SEL_HIGH: begin
              next_r.sel[CMD_ARG_I[sms_pkg::SEL_W-1:0]] = 1'b1;
            end
            sms_pkg::CMD_SELECT: begin
              next_r.sel_idx = CMD_ARG_I[sms_pkg::SEL_W-1:0];
            end
            sms_pkg::CMD_WIDTH: begin
              if (CMD_ARG_I == 16'h0000 ||
                  CMD_ARG_I > 16'(sms_pkg::WIDTH_MAX)) begin
                next_r.err = 1'b1;
              end else begin
                next_r.width = CMD_ARG_I[4:0];
              end
            end
            default: next_r.err = 1'b1;
          endcase
        end
      end
      sms_pkg::H_GATHER: begin
        if (tx_acc) begin
          next_r.txs = {r.txs[7:0], TX_BYTE_I};
          next_r.remain = r.remain - 16'h0001;
          next_r.bcnt = r.bcnt + 2'h1;
          if (r.bcnt + 2'h1 == bps) begin
            next_r.txs = {r.txs[7:0], TX_BYTE_I} & mask;
            next_r.tx_rdy = 1'b0;
            next_r.req = ~r.req;
            next_r.st = sms_pkg::H_WAIT;
          end
        end
      end
      sms_pkg::H_WAIT: begin
        if (ack_s != r.ack_seen) begin
          next_r.ack_seen = ack_s;
          next_r.rxs = link_rx & mask;
          next_r.bcnt = bps;
          next_r.st = sms_pkg::H_EMIT;
        end
      end
      sms_pkg::H_EMIT: begin
        next_r.rx_vld = 1'b1;
        // Upper byte first: big-endian sample order
        next_r.rx_byte = (r.bcnt == 2'h2) ? r.rxs[15:8] : r.rxs[7:0];
        next_r.rcount = r.rcount + 16'h0001;
        next_r.bcnt = r.bcnt - 2'h1;
        if (r.bcnt == 2'h1) begin
          next_r.bcnt = 2'h0;
          if (r.remain != 16'h0000) begin
            next_r.tx_rdy = 1'b1;
            next_r.st = sms_pkg::H_GATHER;
          end else if (r.tail) begin
            next_r.tx_rdy = 1'b1;
            next_r.st = sms_pkg::H_DROP;
          end else begin
            next_r.sel[r.sel_idx] = r.prev;
            next_r.done = 1'b1;
            next_r.cmd_rdy = 1'b1;
            next_r.st = sms_pkg::H_IDLE;
          end
        end
      end
      sms_pkg::H_DROP: begin
        // Tail byte is consumed but never shifted
        if (tx_acc) begin
          next_r.tx_rdy = 1'b0;
          next_r.warn = 1'b1;
          next_r.sel[r.sel_idx] = r.prev;
          next_r.done = 1'b1;
          next_r.cmd_rdy = 1'b1;
          next_r.st = sms_pkg::H_IDLE;
        end
      end
      default: next_r = host_reset();
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      r <= host_reset();
      r.ack_seen <= ack_s;
    end else begin
      r <= next_r;
    end
  end

  assign CMD_READY_O = r.cmd_rdy;
  assign TX_READY_O = r.tx_rdy;
  assign RX_VALID_O = r.rx_vld;
  assign RX_BYTE_O = r.rx_byte;
  assign DONE_O = r.done;
  assign WARN_O = r.warn;
  assign ERR_O = r.err;
  assign RECEIVE_BYTE_COUNT_O = r.rcount;
  assign SELECT_O = r.sel;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence ex_start_s;
    cmd_acc && CMD_CODE_I == sms_pkg::CMD_EXCHANGE && CMD_ARG_I != 16'h0000
      ##1 r.st == sms_pkg::H_GATHER;
  endsequence

  sequence ex_end_s;
    $rose(r.cmd_rdy) && !r.warn && !r.err;
  endsequence

  zero_len_a: assert property (
    cmd_acc && CMD_CODE_I == sms_pkg::CMD_EXCHANGE && CMD_ARG_I == 16'h0000
      |=> r.err && r.done && r.st == sms_pkg::H_IDLE)
    else $error("zero length exchange not refused");
  rx_equal_a: assert property (ex_end_s |-> r.rcount == r.total)
    else $error("receive count differs from transmit count");
  rx_upper_a: assert property (
    r.st == sms_pkg::H_WAIT && ack_s != r.ack_seen
      |-> (link_rx & ~mask) == 16'h0000)
    else $error("received padding bits not zero");
  tx_pad_a: assert property (
    $changed(r.req) |-> (r.txs & ~mask) == 16'h0000)
    else $error("padding bits sent to shifter");
  drop_warn_a: assert property (
    r.st == sms_pkg::H_DROP && tx_acc
      |=> r.warn && r.done ##1 (!r.done || $past(cmd_acc)))
    else $error("partial sample without warning");
  reset_mode_a: assert property (
    $past(RST_I) |-> r.pol == 1'b0 && r.pha == 1'b0)
    else $error("mode defaults wrong after reset");
  reset_cfg_a: assert property (
    $past(RST_I) |-> r.width == 5'h08 && r.rate_idx == 3'h3 &&
      r.sel_idx == 2'h0)
    else $error("configuration defaults wrong after reset");
  rate_fall_a: assert property (
    cmd_acc && CMD_CODE_I == sms_pkg::CMD_RATE && CMD_ARG_I == 16'h0BB8
      |=> r.warn && !r.err && r.rate_idx == 3'h2)
    else $error("unsupported rate not lowered with warning");
  rate_low_a: assert property (
    cmd_acc && CMD_CODE_I == sms_pkg::CMD_RATE && CMD_ARG_I < 16'h0032
      |=> r.err && $stable(r.rate_idx))
    else $error("too low rate not refused");
  mode_apply_a: assert property (
    cmd_acc && CMD_CODE_I == sms_pkg::CMD_MODE
      |=> r.pol == $past(CMD_ARG_I[0]) && r.pha == $past(CMD_ARG_I[1]))
    else $error("mode command not applied");
  sel_high_a: assert property (
    cmd_acc && CMD_CODE_I == sms_pkg::CMD_SEL_HIGH
      |=> r.sel[$past(CMD_ARG_I[1:0])])
    else $error("select line not driven high");
  sel_low_a: assert property (
    cmd_acc && CMD_CODE_I == sms_pkg::CMD_SEL_LOW
      |=> !r.sel[$past(CMD_ARG_I[1:0])])
    else $error("select line not driven low");
  sel_held_a: assert property (ex_start_s |-> !r.sel[r.sel_idx])
    else $error("select not asserted for exchange");
  sel_busy_a: assert property (
    r.st == sms_pkg::H_WAIT |-> !r.sel[r.sel_idx])
    else $error("select released while shifting");

endmodule : sms_top
`default_nettype wire

// file: tb_spi_master_scripted_transfer.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_spi_master_scripted_transfer;
  logic clk, rst, lclk, vld, txv, pol, pha;
  logic [2:0] code;
  logic [15:0] arg, resp, rxw, got;
  logic [7:0] tb;
  logic [3:0] ssel;
  wire logic rdy, txr, rxv, done, warn, err, sclk, mosi, miso;
  wire logic [7:0] rxb;
  wire logic [15:0] cnt;
  wire logic [3:0] sel;
  int seed, err_count, n_tests, nrx, edges, half;
  sms_top sms_top_inst (.CLK_I(clk), .RST_I(rst), .LINK_CLK_I(lclk),
    .CMD_VALID_I(vld), .CMD_CODE_I(code), .CMD_ARG_I(arg),
    .CMD_READY_O(rdy), .TX_VALID_I(txv), .TX_BYTE_I(tb), .TX_READY_O(txr),
    .RX_VALID_O(rxv), .RX_BYTE_O(rxb), .DONE_O(done), .WARN_O(warn),
    .ERR_O(err), .RECEIVE_BYTE_COUNT_O(cnt), .SERIAL_CLK_O(sclk),
    .MOSI_O(mosi), .MISO_I(miso), .SELECT_O(sel));
  sms_slave sms_slave_inst (.sclk_i(sclk), .mosi_i(mosi), .sel_i(sel),
    .miso_o(miso), .pol_i(pol), .pha_i(pha), .resp_i(resp), .got_o(got),
    .edges_o(edges), .half_o(half));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #1;
    forever #3 lclk = ~lclk;
  end
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  function automatic int half_ns(input int khz);
    return (166666 / (2 * khz)) * 6;
  endfunction : half_ns
  task automatic cmd(input logic [2:0] c, input logic [15:0] a);
    int n;
    n = 0;
    // Let an edge pass so valid is never raised in the step that dropped it
    @(negedge clk);
    while (rdy !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) err_count++;
    vld = 1'b1;
    code = c;
    arg = a;
    @(negedge clk);
    vld = 1'b0;
  endtask : cmd
  // Feeds bytes while ready and gathers every receive pulse until done
  task automatic xchg(input int nb, input logic [23:0] d);
    int i, t;
    i = 0;
    t = 0;
    rxw = 16'h0000;
    nrx = 0;
    ssel = 4'hf;
    cmd(3'h0, 16'(nb));
    while (done !== 1'b1 && t < 20000) begin
      if (txv) i++;
      txv = (i < nb) && (txr === 1'b1);
      tb = d[23 - 8 * (i % 3) -: 8];
      if (rxv === 1'b1) begin
        rxw = {rxw[7:0], rxb};
        nrx++;
      end
      if (sel !== 4'hf) ssel = sel;
      @(negedge clk);
      t++;
    end
    txv = 1'b0;
    // Without a tail, the last byte of an exchange arrives together with the done pulse
    if (rxv === 1'b1) begin
      rxw = {rxw[7:0], rxb};
      nrx++;
    end
    if (t == 20000) err_count++;
  endtask : xchg
  task automatic run(input int w, input int nb, input int s, input int khz);
    logic [15:0] tx, rv, m, sv;
    int bp;
    tx = 16'($random(seed));
    rv = 16'($random(seed));
    bp = (w > 8) ? 2 : 1;
    m = 16'((1 << w) - 1);
    sv = (bp == 1) ? {8'h00, tx[7:0]} : tx;
    resp = rv << (16 - w);
    // Third byte is a tail that is consumed but never shifted
    xchg(nb, (bp == 1) ? {tx[7:0], 16'h0000} : {tx, 8'ha5});
    `CHK("mosi", sv & m, got & m)
    `CHK("miso", rv & m, rxw)
    `CHK("count", 16'(bp), cnt)
    `CHK("nrx", bp, nrx)
    `CHK("warn", 1'(nb % bp), warn)
    `CHK("edges", 2 * w, edges)
    `CHK("half", half_ns(khz), half)
    `CHK("sel", ~(4'h1 << s), ssel)
    `CHK("idle", pol, sclk)
    `CHK("rel", 4'hf, sel)
  endtask : run
  task automatic setc(input logic [2:0] c, input int a, input logic w,
    input logic e);
    int t;
    t = 0;
    cmd(c, 16'(a));
    while (done !== 1'b1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    `CHK("cwarn", w, warn)
    `CHK("cerr", e, err)
  endtask : setc
  initial begin
    #1_500_000;
    err_count++;
    complete_run();
  end
  initial begin
    int rq[3];
    rq = '{49, 100, 3000};
    seed = 6;
    {rst, vld, txv, pol, pha} = 5'b10000;
    {code, arg, tb, resp} = '0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    `CHK("ready", 1'b1, rdy)
    `CHK("txr", 1'b0, txr)
    `CHK("sclk", 1'b0, sclk)
    `CHK("sels", 4'hf, sel)
    run(8, 1, 0, 1000);
    setc(3'h2, 8000, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      pol = i[0];
      pha = i[1];
      setc(3'h1, i, 1'b0, 1'b0);
      setc(3'h5, i, 1'b0, 1'b0);
      setc(3'h6, 4 * i + 4, 1'b0, 1'b0);
      run(4 * i + 4, (i > 1) ? 2 : 1, i, 8000);
    end
    for (int i = 0; i < 3; i++) begin
      setc(3'h2, rq[i], 1'(i == 2), 1'(i == 0));
    end
    run(16, 3, 3, 2000);
    setc(3'h0, 0, 1'b0, 1'b1);
    setc(3'h3, 1, 1'b0, 1'b0);
    `CHK("low", 4'hd, sel)
    setc(3'h4, 1, 1'b0, 1'b0);
    `CHK("high", 4'hf, sel)
    setc(3'h6, 17, 1'b0, 1'b1);
    setc(3'h7, 0, 1'b0, 1'b1);
    complete_run();
  end
endmodule : tb_spi_master_scripted_transfer
`default_nettype wire
